//--- rtl/asd_decoder.sv
`timescale 1ns/100ps
// Behaviour
// - four segment prefix bytes select a segment for the next instruction, two clocks
// - add register with register or memory, direction and width bits, 3/10 clocks
// - add with carry: register/memory 3/10, immediate group 4/16, accumulator 3/4
// - subtract: register/memory 3/10, immediate group 4/16, accumulator 3/4
// - subtract with borrow: register/memory 3/10, immediate group 4/16, accumulator 3/4
// - unary group reg field 3 negates register or memory, 3/10 clocks
// - ascii adjust after add, one byte, 8 clocks
// - decimal adjust after add, one byte, 4 clocks
// - ascii adjust after subtract, one byte, 7 clocks
// - decimal adjust after subtract, one byte, 4 clocks
// - unary group reg field 4 is unsigned multiply with per-form clock ranges
module asd_decoder (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic q_valid,
  input wire logic [7:0] q_byte,
  output logic q_ready,
  output logic res_valid,
  output asd_pkg::asd_res_t res,
  output logic instr_busy
);
  import asd_pkg::*;

  asd_state_t st_q, st_d;
  logic [7:0] opc_q, opc_d, mrm_q, mrm_d;
  logic [2:0] cnt_q, cnt_d;
  asd_res_t res_q, res_d;
  logic vld_q, vld_d;
  logic segv_q, segv_d;
  asd_seg_t seg_q, seg_d;

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // alu family code shared by one-byte forms and the immediate group
  function automatic asd_op_t alu_op(input logic [2:0] sel);
    unique case (sel)
      REG_ADD: alu_op = add_op;
      REG_ADC: alu_op = add_carry_op;
      REG_SUB_BORROW: alu_op = subtract_borrow_op;
      REG_SUB: alu_op = subtract_op;
      REG_COMPARE: alu_op = compare_op;
      default: alu_op = illegal_op; // logic group, reported as illegal_op
    endcase
  endfunction

  function automatic logic [1:0] disp_len(input logic [7:0] mrm);
    unique case (mrm[7:6])
      MOD_NODISP: disp_len = (mrm[2:0] == RM_DIRECT) ? LEN_TWO : LEN_NONE;
      MOD_DISP8: disp_len = LEN_ONE;
      MOD_DISP16: disp_len = LEN_TWO;
      MOD_REG: disp_len = LEN_NONE;
    endcase
  endfunction

  function automatic logic is_alu(input logic [7:0] opc);
    is_alu = (opc[7:6] == OPC_ALU_TOP) && (opc[2:1] != OPC_ALU_MISC);
  endfunction

  function automatic logic needs_modrm(input logic [7:0] opc);
    needs_modrm = (is_alu(opc) && !opc[2]) || ((opc & OPC_IMM_MASK) == OPC_IMM_GRP) ||
                  ((opc & OPC_PAIR_MASK) == OPC_INCDEC_GRP) ||
                  ((opc & OPC_PAIR_MASK) == OPC_UNARY_GRP);
  endfunction

  // full classification; mrm is zero for forms without a modrm byte
  function automatic asd_res_t classify(input logic [7:0] opc, input logic [7:0] mrm);
    asd_res_t r;
    logic mem;
    logic [2:0] rg;
    asd_cyc_t c;
    mem = (mrm[7:6] != MOD_REG);
    rg = mrm[5:3];
    r = '0;
    r.op = illegal_op;
    r.wide = opc[0];
    c = '0;
    if ((opc & OPC_PFX_MASK) == OPC_PFX)
    begin
      r.op = seg_override_op;
      r.seg = asd_seg_t'(opc[4:3]);
      r.seg_valid = 1'b1;
      r.wide = 1'b0;
      c = CYC_PREFIX;
    end
    else if (opc == OPC_ASCII_ADD)
    begin
      r.op = ascii_add_adjust;
      r.wide = 1'b0;
      c = CYC_ASCII_ADD;
    end
    else if (opc == OPC_DECIMAL_ADD)
    begin
      r.op = decimal_add_adjust;
      r.wide = 1'b0;
      c = CYC_DECIMAL_ADD;
    end
    else if (opc == OPC_ASCII_SUB)
    begin
      r.op = ascii_sub_adjust;
      r.wide = 1'b0;
      c = CYC_ASCII_SUB;
    end
    else if (opc == OPC_DECIMAL_SUB)
    begin
      r.op = decimal_sub_adjust;
      r.wide = 1'b0;
      c = CYC_DECIMAL_SUB;
    end
    else if (is_alu(opc))
    begin
      r.op = alu_op(opc[5:3]);
      if (!opc[2])
      begin
        r.dir = opc[1];
        r.mem = mem;
        r.disp_len = disp_len(mrm);
        c = mem ? CYC_ALU_MEM : CYC_ALU_REG;
      end
      else
      begin
        // accumulator form: byte 3, word 4
        r.imm_len = opc[0] ? LEN_TWO : LEN_ONE;
        c = opc[0] ? CYC_ACC_W : CYC_ACC_B;
      end
    end
    else if ((opc & OPC_IMM_MASK) == OPC_IMM_GRP)
    begin
      r.op = alu_op(rg);
      r.mem = mem;
      r.disp_len = disp_len(mrm);
      r.sext = opc[1] & opc[0];
      r.imm_len = (opc[1:0] == SW_WORD_IMM) ? LEN_TWO : LEN_ONE;
      if (r.op == compare_op)
        c = mem ? CYC_CMPI_MEM : CYC_CMPI_REG;
      else
        c = mem ? CYC_IMM_MEM : CYC_IMM_REG;
    end
    else if ((opc & OPC_REG_MASK) == OPC_INC_REG || (opc & OPC_REG_MASK) == OPC_DECR_REG)
    begin
      r.op = (opc[3]) ? decrement_op : increment_op;
      r.wide = 1'b1;
      c = CYC_INC_REG;
    end
    else if ((opc & OPC_PAIR_MASK) == OPC_INCDEC_GRP)
    begin
      r.mem = mem;
      r.disp_len = disp_len(mrm);
      if (rg == REG_INC || rg == REG_DECR)
      begin
        r.op = (rg == REG_DECR) ? decrement_op : increment_op;
        c = mem ? CYC_INC_MEM : CYC_INC_REG;
      end
    end
    else if ((opc & OPC_PAIR_MASK) == OPC_UNARY_GRP)
    begin
      r.mem = mem;
      r.disp_len = disp_len(mrm);
      if (rg == REG_NEGATE)
      begin
        r.op = negate_op;
        c = mem ? CYC_NEGATE_MEM : CYC_NEGATE_REG;
      end
      else if (rg == REG_UMULT)
      begin
        r.op = unsigned_multiply_op;
        c = mem ? (opc[0] ? CYC_UMULT_MW_MIN : CYC_UMULT_MB_MIN) :
                  (opc[0] ? CYC_UMULT_RW_MIN : CYC_UMULT_RB_MIN);
        r.cyc_max = mem ? (opc[0] ? CYC_UMULT_MW_MAX : CYC_UMULT_MB_MAX) :
                          (opc[0] ? CYC_UMULT_RW_MAX : CYC_UMULT_RB_MAX);
      end
    end
    r.cyc_min = c;
    if (r.op != unsigned_multiply_op)
      r.cyc_max = c;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // byte sequencer: opcode, modrm, then displacement and immediate bytes

  always_comb
  begin
    asd_res_t r;
    logic fin;
    logic [2:0] tl;
    r = '0;
    fin = 1'b0;
    tl = '0;
    st_d = st_q;
    opc_d = opc_q;
    mrm_d = mrm_q;
    cnt_d = cnt_q;
    res_d = res_q;
    vld_d = 1'b0;
    segv_d = segv_q;
    seg_d = seg_q;
    unique case (st_q)
      ST_OPC:
        if (q_valid)
        begin
          opc_d = q_byte;
          mrm_d = '0;
          r = classify(q_byte, 8'h00);
          if (needs_modrm(q_byte))
            st_d = ST_MODRM;
          else if (r.imm_len != LEN_NONE)
          begin
            cnt_d = {1'b0, r.imm_len};
            st_d = ST_TAIL;
          end
          else
            fin = 1'b1;
        end
      ST_MODRM:
        if (q_valid)
        begin
          mrm_d = q_byte;
          r = classify(opc_q, q_byte);
          tl = {1'b0, r.disp_len} + {1'b0, r.imm_len};
          if (tl == 3'h0)
            fin = 1'b1;
          else
          begin
            cnt_d = tl;
            st_d = ST_TAIL;
          end
        end
      ST_TAIL:
        if (q_valid)
        begin
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == 3'h1)
          begin
            r = classify(opc_q, mrm_q);
            fin = 1'b1;
          end
        end
      default: st_d = ST_OPC;
    endcase
    // a prefix is held and attached to the next instruction reported
    if (fin)
    begin
      st_d = ST_OPC;
      vld_d = 1'b1;
      res_d = r;
      if (r.op == seg_override_op)
      begin
        segv_d = 1'b1;
        seg_d = r.seg;
      end
      else
      begin
        res_d.seg = seg_q;
        res_d.seg_valid = segv_q;
        segv_d = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_q <= ST_OPC;
      opc_q <= '0;
      mrm_q <= '0;
      cnt_q <= '0;
      res_q <= '0;
      vld_q <= 1'b0;
      segv_q <= 1'b0;
      seg_q <= extra_segment;
    end
    else
    begin
      st_q <= st_d;
      opc_q <= opc_d;
      mrm_q <= mrm_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      vld_q <= vld_d;
      segv_q <= segv_d;
      seg_q <= seg_d;
    end
  end

  // never stalls the queue: every state takes one byte per clock
  assign q_ready = 1'b1;
  assign res_valid = vld_q;
  assign res = res_q;
  assign instr_busy = (st_q != ST_OPC);

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_prefix_result: assert property (
    st_q == ST_OPC && q_valid && (q_byte & OPC_PFX_MASK) == OPC_PFX |=> vld_q &&
    res_q.op == seg_override_op && res_q.cyc_min == CYC_PREFIX &&
    res_q.seg == asd_seg_t'(opc_q[4:3])) else $error("prefix not reported");
  a_add_rm_cycles: assert property (
    vld_q && res_q.op == add_op && res_q.imm_len == LEN_NONE |->
    res_q.cyc_min == (res_q.mem ? CYC_ALU_MEM : CYC_ALU_REG)) else $error("add cycles");
  a_adc_imm_mem: assert property (
    vld_q && res_q.op == add_carry_op && res_q.mem && res_q.imm_len != LEN_NONE |->
    res_q.cyc_min == CYC_IMM_MEM) else $error("adc immediate cycles");
  a_sub_word_imm: assert property (
    vld_q && res_q.op == subtract_op && !res_q.mem && res_q.imm_len == LEN_TWO |->
    res_q.cyc_min == CYC_ACC_W) else $error("sub word immediate cycles");
  a_borrow_rm_mem: assert property (
    vld_q && res_q.op == subtract_borrow_op && res_q.imm_len == LEN_NONE && res_q.mem |->
    res_q.cyc_min == CYC_ALU_MEM) else $error("subtract borrow memory cycles");
  a_negate_cycles: assert property (
    vld_q && res_q.op == negate_op |-> res_q.imm_len == LEN_NONE &&
    res_q.cyc_min == (res_q.mem ? CYC_NEGATE_MEM : CYC_NEGATE_REG))
    else $error("negate cycles");
  a_ascii_add_single: assert property (
    st_q == ST_OPC && q_valid && q_byte == OPC_ASCII_ADD |=> vld_q &&
    res_q.op == ascii_add_adjust && res_q.cyc_min == CYC_ASCII_ADD)
    else $error("ascii add adjust decode");
  a_decimal_add_single: assert property (
    st_q == ST_OPC && q_valid && q_byte == OPC_DECIMAL_ADD |=> vld_q &&
    res_q.op == decimal_add_adjust && res_q.cyc_min == CYC_DECIMAL_ADD)
    else $error("decimal add adjust decode");
  a_ascii_sub_single: assert property (
    st_q == ST_OPC && q_valid && q_byte == OPC_ASCII_SUB |=> vld_q &&
    res_q.op == ascii_sub_adjust && res_q.cyc_min == CYC_ASCII_SUB)
    else $error("ascii sub adjust decode");
  a_decimal_sub_single: assert property (
    st_q == ST_OPC && q_valid && q_byte == OPC_DECIMAL_SUB |=> vld_q &&
    res_q.op == decimal_sub_adjust && res_q.cyc_min == CYC_DECIMAL_SUB)
    else $error("decimal sub adjust decode");
  a_umult_range: assert property (
    vld_q && res_q.op == unsigned_multiply_op && res_q.mem && res_q.wide |->
    res_q.cyc_min == CYC_UMULT_MW_MIN && res_q.cyc_max == CYC_UMULT_MW_MAX)
    else $error("multiply memory word range");
  a_imm_len_sw: assert property (
    vld_q && (opc_q & OPC_IMM_MASK) == OPC_IMM_GRP |->
    res_q.imm_len == ((opc_q[1:0] == SW_WORD_IMM) ? LEN_TWO : LEN_ONE))
    else $error("immediate length");
  a_incdec_mem: assert property (
    vld_q && (res_q.op == increment_op || res_q.op == decrement_op) && res_q.mem |->
    res_q.cyc_min == CYC_INC_MEM) else $error("increment or decrement memory cycles");
  a_tail_ends: assert property (
    st_q == ST_TAIL && cnt_q == 3'h1 && q_valid |=> vld_q && st_q == ST_OPC)
    else $error("tail did not finish");

  c_prefix_then_op: cover property (vld_q && res_q.op != seg_override_op && res_q.seg_valid);
  c_umult_word: cover property (vld_q && res_q.op == unsigned_multiply_op && res_q.wide);
  c_imm_two: cover property (vld_q && res_q.imm_len == LEN_TWO && res_q.disp_len == LEN_TWO);
  c_back_to_back: cover property (vld_q ##1 vld_q);

endmodule

//--- rtl/asd_pkg.sv
package asd_pkg;

  localparam int CYC_W = 8;
  typedef logic [CYC_W-1:0] asd_cyc_t;

  // operation classes reported per decoded instruction
  typedef enum logic [3:0] {
    illegal_op, seg_override_op, add_op, add_carry_op, increment_op,
    subtract_op, subtract_borrow_op, decrement_op, compare_op, negate_op,
    ascii_add_adjust, decimal_add_adjust, ascii_sub_adjust, decimal_sub_adjust,
    unsigned_multiply_op
  } asd_op_t;

  // segment select sits in opcode bits 4:3 of a prefix
  typedef enum logic [1:0] {
    extra_segment = 2'h0, code_segment = 2'h1, stack_segment = 2'h2, data_segment = 2'h3
  } asd_seg_t;

  typedef enum logic [1:0] {ST_OPC = 2'h0, ST_MODRM = 2'h1, ST_TAIL = 2'h3} asd_state_t;

  typedef struct packed {
    asd_op_t op;
    asd_seg_t seg;
    logic seg_valid;
    logic wide;
    logic dir;
    logic mem;
    logic sext;
    logic [1:0] imm_len;
    logic [1:0] disp_len;
    asd_cyc_t cyc_min;
    asd_cyc_t cyc_max;
  } asd_res_t;

  // opcode patterns
  localparam logic [7:0] OPC_PFX_MASK = 8'hE7;
  localparam logic [7:0] OPC_PFX = 8'h26;
  localparam logic [7:0] OPC_IMM_MASK = 8'hFC;
  localparam logic [7:0] OPC_IMM_GRP = 8'h80;
  localparam logic [7:0] OPC_PAIR_MASK = 8'hFE;
  localparam logic [7:0] OPC_INCDEC_GRP = 8'hFE;
  localparam logic [7:0] OPC_UNARY_GRP = 8'hF6;
  localparam logic [7:0] OPC_REG_MASK = 8'hF8;
  localparam logic [7:0] OPC_INC_REG = 8'h40;
  localparam logic [7:0] OPC_DECR_REG = 8'h48;
  localparam logic [7:0] OPC_ASCII_ADD = 8'h37;
  localparam logic [7:0] OPC_DECIMAL_ADD = 8'h27;
  localparam logic [7:0] OPC_ASCII_SUB = 8'h3F;
  localparam logic [7:0] OPC_DECIMAL_SUB = 8'h2F;
  localparam logic [1:0] OPC_ALU_TOP = 2'h0;
  localparam logic [1:0] OPC_ALU_MISC = 2'h3;
  localparam logic [1:0] SW_WORD_IMM = 2'h1;

  // reg field selectors of the group opcodes
  localparam logic [2:0] REG_ADD = 3'h0;
  localparam logic [2:0] REG_ADC = 3'h2;
  localparam logic [2:0] REG_SUB_BORROW = 3'h3;
  localparam logic [2:0] REG_SUB = 3'h5;
  localparam logic [2:0] REG_COMPARE = 3'h7;
  localparam logic [2:0] REG_INC = 3'h0;
  localparam logic [2:0] REG_DECR = 3'h1;
  localparam logic [2:0] REG_NEGATE = 3'h3;
  localparam logic [2:0] REG_UMULT = 3'h4;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  // minimum clock counts, and multiply maxima
  localparam asd_cyc_t CYC_PREFIX = 8'h02;
  localparam asd_cyc_t CYC_ALU_REG = 8'h03;
  localparam asd_cyc_t CYC_ALU_MEM = 8'h0A;
  localparam asd_cyc_t CYC_IMM_REG = 8'h04;
  localparam asd_cyc_t CYC_IMM_MEM = 8'h10;
  localparam asd_cyc_t CYC_CMPI_REG = 8'h03;
  localparam asd_cyc_t CYC_CMPI_MEM = 8'h0A;
  localparam asd_cyc_t CYC_ACC_B = 8'h03;
  localparam asd_cyc_t CYC_ACC_W = 8'h04;
  localparam asd_cyc_t CYC_INC_REG = 8'h03;
  localparam asd_cyc_t CYC_INC_MEM = 8'h0F;
  localparam asd_cyc_t CYC_NEGATE_REG = 8'h03;
  localparam asd_cyc_t CYC_NEGATE_MEM = 8'h0A;
  localparam asd_cyc_t CYC_ASCII_ADD = 8'h08;
  localparam asd_cyc_t CYC_DECIMAL_ADD = 8'h04;
  localparam asd_cyc_t CYC_ASCII_SUB = 8'h07;
  localparam asd_cyc_t CYC_DECIMAL_SUB = 8'h04;
  localparam asd_cyc_t CYC_UMULT_RB_MIN = 8'h1A;
  localparam asd_cyc_t CYC_UMULT_RB_MAX = 8'h1C;
  localparam asd_cyc_t CYC_UMULT_RW_MIN = 8'h23;
  localparam asd_cyc_t CYC_UMULT_RW_MAX = 8'h25;
  localparam asd_cyc_t CYC_UMULT_MB_MIN = 8'h20;
  localparam asd_cyc_t CYC_UMULT_MB_MAX = 8'h22;
  localparam asd_cyc_t CYC_UMULT_MW_MIN = 8'h29;
  localparam asd_cyc_t CYC_UMULT_MW_MAX = 8'h2B;

endpackage

//--- testbench/asd_queue_model.sv
`timescale 1ns/100ps
// prefetch queue stand-in: bytes go out in push order, with random gaps
module asd_queue_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic q_ready,
  input wire logic [6:0] stall_pct,
  output logic q_valid,
  output logic [7:0] q_byte
);
  logic [7:0] fifo[$];

  initial
  begin
    q_valid = 1'b0;
    q_byte = 8'h00;
  end

  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // idle byte flips each cycle, so a stale byte never passes as a fresh one
  always @(posedge ref_clk)
  begin
    if (!resetn)
      fifo.delete();
    else if (q_valid && q_ready)
      void'(fifo.pop_front());
    if (resetn && fifo.size() > 0 && ($urandom % 100) >= stall_pct)
    begin
      q_valid <= 1'b1;
      q_byte <= fifo[0];
    end
    else
    begin
      q_valid <= 1'b0;
      q_byte <= ~q_byte;
    end
  end
endmodule

//--- testbench/tb_arith_segment_opcode_decoder.sv
`timescale 1ns/100ps
`define CHK(w, e, g) chk(w, 32'(e), 32'(g))
module tb_arith_segment_opcode_decoder;
  import asd_pkg::*;
  typedef struct {asd_res_t r; logic hm; logic dk; logic sk; int n;} asd_exp_t;
  logic ref_clk, resetn, q_valid, q_ready, res_valid, instr_busy, prev_take, hv;
  logic [7:0] q_byte;
  logic [6:0] stall_pct;
  asd_res_t res;
  asd_seg_t hs;
  asd_exp_t exp_q[$];
  logic [7:0] tbl[$];
  int errors, n_compared, cnt;

  asd_decoder u_dut (.ref_clk(ref_clk), .resetn(resetn), .q_valid(q_valid), .q_byte(q_byte),
    .q_ready(q_ready), .res_valid(res_valid), .res(res), .instr_busy(instr_busy));
  asd_queue_model u_q (.ref_clk(ref_clk), .resetn(resetn), .q_ready(q_ready),
    .stall_pct(stall_pct), .q_valid(q_valid), .q_byte(q_byte));

  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", w, e, g);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic asd_op_t alu(input logic [2:0] f);
    case (f)
      3'h0: return add_op;
      3'h2: return add_carry_op;
      3'h3: return subtract_borrow_op;
      3'h5: return subtract_op;
      3'h7: return compare_op;
      default: return illegal_op;
    endcase
  endfunction

  function automatic logic covered(input logic [7:0] o);
    return (o & 8'hE7) == 8'h26 || o[7:4] == 4'h4 || o[7:2] == 6'h20 || o[7:1] == 7'h7F
      || o[7:1] == 7'h7B || (o[7:5] == 3'h1 && o[2:0] == 3'h7)
      || (o[7:6] == 2'h0 && o[2:1] != 2'h3 && alu(o[5:3]) != illegal_op);
  endfunction

  function automatic asd_res_t rs(input asd_op_t op, input logic [7:0] c, input logic w);
    rs = '0;
    rs.op = op;
    rs.cyc_min = c;
    rs.cyc_max = c;
    rs.wide = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // expected result and byte count of one instruction
  function automatic asd_exp_t build(input logic [7:0] o, input logic [7:0] m);
    asd_exp_t e;
    logic mf;
    logic ac;
    logic [7:0] c;
    mf = m[7:6] != 2'h3;
    ac = o[7:6] == 2'h0 && o[2:1] == 2'h2;
    e.hm = (o[7:6] == 2'h0 && !o[2]) || o[7];
    e.dk = o[7:6] == 2'h0 && !o[2];
    e.sk = o[7:2] == 6'h20;
    c = mf ? (o[0] ? 8'h29 : 8'h20) : (o[0] ? 8'h23 : 8'h1A);
    if ((o & 8'hE7) == 8'h26)
      e.r = rs(seg_override_op, 8'h02, 1'b0);
    else if (o == 8'h37)
      e.r = rs(ascii_add_adjust, 8'h08, 1'b0);
    else if (o == 8'h27)
      e.r = rs(decimal_add_adjust, 8'h04, 1'b0);
    else if (o == 8'h3F)
      e.r = rs(ascii_sub_adjust, 8'h07, 1'b0);
    else if (o == 8'h2F)
      e.r = rs(decimal_sub_adjust, 8'h04, 1'b0);
    else if (e.dk)
      e.r = rs(alu(o[5:3]), mf ? 8'h0A : 8'h03, o[0]);
    else if (ac)
      e.r = rs(alu(o[5:3]), o[0] ? 8'h04 : 8'h03, o[0]);
    else if (o[7:4] == 4'h4)
      e.r = rs(o[3] ? decrement_op : increment_op, 8'h03, 1'b1);
    else if (e.sk && m[5:3] == 3'h7)
      e.r = rs(compare_op, mf ? 8'h0A : 8'h03, o[0]);
    else if (e.sk)
      e.r = rs(alu(m[5:3]), mf ? 8'h10 : 8'h04, o[0]);
    else if (o[7:1] == 7'h7F)
      e.r = rs(m[5:4] != 2'h0 ? illegal_op : m[3] ? decrement_op : increment_op,
        mf ? 8'h0F : 8'h03, o[0]);
    else if (m[5:3] == 3'h3)
      e.r = rs(negate_op, mf ? 8'h0A : 8'h03, o[0]);
    else if (m[5:3] == 3'h4)
      e.r = rs(unsigned_multiply_op, c, o[0]);
    else
      e.r = rs(illegal_op, 8'h00, o[0]);
    // logic-group immediates keep their timing and still take their data bytes
    if (e.r.op == illegal_op && !e.sk)
      e.r.cyc_min = 8'h00;
    if (e.r.op == unsigned_multiply_op)
      e.r.cyc_max = c + 8'h02;
    e.r.mem = e.hm & mf;
    e.r.disp_len = !e.hm ? 2'h0 : m[7:6] == 2'h1 ? 2'h1
      : (m[7:6] == 2'h2 || (m[7:6] == 2'h0 && m[2:0] == 3'h6)) ? 2'h2 : 2'h0;
    e.r.dir = e.dk & o[1];
    e.r.sext = e.sk & o[1] & o[0];
    if (ac || e.sk)
      e.r.imm_len = (ac ? o[0] : o[1:0] == 2'h1) ? 2'h2 : 2'h1;
    e.n = 1 + int'(e.hm) + int'(e.r.disp_len) + int'(e.r.imm_len);
    return e;
  endfunction

  // queue the expectation, then the bytes; a prefix is held for the next one
  task automatic send(input logic [7:0] o, input logic [7:0] m);
    asd_exp_t e;
    e = build(o, m);
    if (e.r.op == seg_override_op)
    begin
      e.r.seg = asd_seg_t'(o[4:3]);
      hv = 1'b1;
      hs = e.r.seg;
    end
    else
    begin
      e.r.seg_valid = hv;
      e.r.seg = hv ? hs : extra_segment;
      hv = 1'b0;
    end
    exp_q.push_back(e);
    u_q.push(o);
    if (e.hm)
      u_q.push(m);
    repeat (e.n - 1 - int'(e.hm)) u_q.push(8'($urandom));
  endtask

  task automatic check(input asd_exp_t e);
    `CHK("op", e.r.op, res.op);
    `CHK("cyc_min", e.r.cyc_min, res.cyc_min);
    `CHK("bytes taken", e.n, cnt);
    `CHK("last byte edge", 1, prev_take);
    `CHK("busy", 0, instr_busy);
    if (e.r.op != illegal_op)
    begin
      `CHK("cyc_max", e.r.cyc_max, res.cyc_max);
      `CHK("wide", e.r.wide, res.wide);
      `CHK("mem", e.r.mem, res.mem);
      `CHK("disp_len", e.r.disp_len, res.disp_len);
      `CHK("imm_len", e.r.imm_len, res.imm_len);
      if (e.r.op != seg_override_op)
        `CHK("seg_valid", e.r.seg_valid, res.seg_valid);
      if (e.r.op == seg_override_op || e.r.seg_valid)
        `CHK("seg", e.r.seg, res.seg);
      if (e.dk)
        `CHK("dir", e.r.dir, res.dir);
      if (e.sk)
        `CHK("sext", e.r.sext, res.sext);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scoreboard: each result pulse against the oldest expectation
  always @(posedge ref_clk)
  begin
    if (!resetn)
      cnt = 0;
    else if (res_valid)
    begin
      if (exp_q.size() == 0)
        `CHK("spare result", 0, 1);
      else
        check(exp_q.pop_front());
      cnt = int'(q_valid);
    end
    else
      cnt += int'(q_valid);
    prev_take = q_valid && resetn;
  end

  task automatic drain(input string name);
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 20000)
    begin
      @(posedge ref_clk);
      k++;
    end
    `CHK("pending results", 0, exp_q.size());
    $display("test %s done", name);
  endtask

  // watchdog: far beyond the few thousand cycles the tests need
  initial
  begin
    #(60000 * 10);
    errors++;
    finish_test();
  end

  initial
  begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    stall_pct = 7'h00;
    hv = 1'b0;
    hs = extra_segment;
    errors = 0;
    n_compared = 0;
    cnt = 0;
    prev_take = 1'b0;
    void'($urandom(32'hC9842F9F));
    for (int o = 0; o < 256; o++)
      if (covered(8'(o)))
        tbl.push_back(8'(o));
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    // one edge more, so the queue model cannot flush bytes pushed under reset
    @(posedge ref_clk);
    // every covered opcode with every mod and reg field, back to back
    foreach (tbl[k])
      for (int j = 0; j < 8; j++)
        send(tbl[k], {2'(j), 3'(j), 3'h6});
    drain("opcode_sweep");
    // a later prefix overrides the held one, and the hold lasts one instruction
    for (int p = 0; p < 4; p++)
    begin
      send({3'h1, 2'(p), 3'h6}, 8'h00);
      send({3'h1, 2'(3 - p), 3'h6}, 8'h00);
      send(8'h03, 8'h47);
      send(8'h05, 8'h00);
    end
    drain("prefix_hold");
    stall_pct <= 7'h28;
    repeat (400) send(tbl[$urandom % tbl.size()], 8'($urandom));
    drain("random_gaps");
    // reset lands mid-instruction while a prefix is held
    send(8'h3E, 8'h00);
    send(8'h81, 8'h80);
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    exp_q.delete();
    hv = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("reset res", 0, res);
    `CHK("reset valid", 0, res_valid);
    `CHK("reset busy", 0, instr_busy);
    `CHK("ready", 1, q_ready);
    @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    send(8'h2D, 8'h00);
    drain("mid_reset");
    finish_test();
  end
endmodule
